// [pkg/msc_pkg.sv]
// constants for the motion sensor configuration register slice
package msc_pkg;
    // widths
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int BANK_W = 3;

    // bank codes
    localparam logic [2:0] BANK_0   = 3'h0;
    localparam logic [2:0] BANK_1   = 3'h1;
    localparam logic [2:0] BANK_MAX = 3'h4;

    // bank 0 offsets
    localparam logic [6:0] OFS_DROPPED_LOW   = 7'h6c;
    localparam logic [6:0] OFS_DROPPED_HIGH  = 7'h6d;
    localparam logic [6:0] OFS_SELFTEST_CTRL = 7'h70;
    localparam logic [6:0] OFS_PART_IDENTITY = 7'h75;
    // present in every bank
    localparam logic [6:0] OFS_BANK_CHOICE   = 7'h76;

    // bank 1 offsets
    localparam logic [6:0] OFS_AXIS_POWER_OFF  = 7'h03;
    localparam logic [6:0] OFS_GYRO_BYPASS     = 7'h0b;
    localparam logic [6:0] OFS_AAF_DELTA       = 7'h0c;
    localparam logic [6:0] OFS_AAF_DSQ_LOW     = 7'h0d;
    localparam logic [6:0] OFS_AAF_SHIFT_DSQ_H = 7'h0e;
    localparam logic [6:0] OFS_NOTCH_X_LOW     = 7'h0f;
    localparam logic [6:0] OFS_NOTCH_Y_LOW     = 7'h10;
    localparam logic [6:0] OFS_NOTCH_Z_LOW     = 7'h11;
    localparam logic [6:0] OFS_NOTCH_HIGH_SEL  = 7'h12;

    // reset values
    localparam logic [7:0] RST_ZERO            = 8'h00;
    localparam logic [7:0] RST_GYRO_BYPASS     = 8'ha8;
    localparam logic [7:0] RST_AAF_DELTA       = 8'h3f;
    localparam logic [7:0] RST_AAF_DSQ_LOW     = 8'h80;
    localparam logic [7:0] RST_AAF_SHIFT_DSQ_H = 8'h3f;

    // writable bit masks; reserved bits are zero here
    localparam logic [7:0] MASK_SELFTEST    = 8'h7f;
    localparam logic [7:0] MASK_BANK_CHOICE = 8'h07;
    localparam logic [7:0] MASK_AXIS_OFF    = 8'h3f;
    localparam logic [7:0] MASK_BYPASS      = 8'h03;
    localparam logic [7:0] MASK_AAF_DELTA   = 8'h3f;
    localparam logic [7:0] MASK_FULL        = 8'hff;
    localparam logic [7:0] MASK_NOTCH_HIGH  = 8'h3f;

    // field positions
    localparam int SELFTEST_SUPPLY_BIT = 6;
    localparam int SELFTEST_EN_MSB     = 5;
    localparam int AXIS_OFF_MSB        = 5;
    localparam int AAF_BYPASS_BIT      = 1;
    localparam int NOTCH_BYPASS_BIT    = 0;
    localparam int AAF_DELTA_MSB       = 5;
    localparam int AAF_SHIFT_MSB       = 7;
    localparam int AAF_SHIFT_LSB       = 4;
    localparam int DSQ_HIGH_MSB        = 3;
    localparam int NOTCH_X_BIT8        = 0;
    localparam int NOTCH_Y_BIT8        = 1;
    localparam int NOTCH_Z_BIT8        = 2;
    localparam int NOTCH_X_SEL         = 3;
    localparam int NOTCH_Y_SEL         = 4;
    localparam int NOTCH_Z_SEL         = 5;
    localparam int BANK_MSB            = 2;
    localparam int COUNT_HIGH_MSB      = 15;
    localparam int COUNT_HIGH_LSB      = 8;
    localparam int COUNT_LOW_MSB       = 7;
endpackage

// [rtl/msc_cfg_byte.sv]
// one writable configuration byte with reset or trim load
`timescale 1ns/100ps
module msc_cfg_byte
    import msc_pkg::*;
#(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] WR_MASK   = 8'hff,
    parameter bit         USE_TRIM  = 1'b0
) (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    input  wire logic [7:0] trim_val,
    output logic      [7:0] value
);
    typedef struct packed {
        logic [7:0] data;
    } msc_byte_state_t;

    msc_byte_state_t st_q;
    msc_byte_state_t st_d;

    // reserved bits never take a written one
    always_comb begin
        st_d = st_q;
        if (wr_en) begin
            st_d.data = wr_data & WR_MASK;
        end
    end

    // trimmed bytes load their calibration while reset is held
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_q.data <= USE_TRIM ? (trim_val & WR_MASK) : (RESET_VAL & WR_MASK);
        end else begin
            st_q <= st_d;
        end
    end

    assign value = st_q.data;
endmodule

// [rtl/msc_regs.sv]
// register slice of the motion sensor: bank 0 tail and bank 1 gyro filter setup
// Summary of operation
// - dropped-packet count low byte readable at bank 0 0x6c, read live from DROPPED_PACKET_COUNT
// - dropped-packet count high byte readable at bank 0 0x6d, read live from DROPPED_PACKET_COUNT
// - self-test control at bank 0 0x70 holds six axis self-test enables
// - fixed eight-bit identity readable at bank 0 0x75
// - identity value is independent of the serial bus target address
// - bank selector at 0x76 is reachable from every bank
// - bank field bits 2:0 picks banks 0-4, bank 0 after reset
// - bank 1 0x03 switches individual gyro and accel axes off
// - all axis-off bits are clear after reset
// - bank 1 0x0b bypasses gyro anti-alias (bit 1) and notch (bit 0)
// - anti-alias delta, delta-squared and shift live at 0x0c to 0x0e
// - nine-bit notch coefficient and select per gyro axis at 0x0f to 0x12
// - notch coefficient registers reset to per-unit factory trim values
`timescale 1ns/100ps
module msc_regs
    import msc_pkg::*;
#(
    parameter logic [7:0] IDENTITY_VALUE = 8'h5a  // arbitrary value
) (
    input  wire logic        CLK,
    input  wire logic        RST_B,
    input  wire logic [6:0]  REG_ADDR,
    input  wire logic        REG_WR_EN,
    input  wire logic [7:0]  REG_WR_DATA,
    input  wire logic        REG_RD_EN,
    output logic      [7:0]  REG_RD_DATA,
    input  wire logic [15:0] DROPPED_PACKET_COUNT,
    input  wire logic [7:0]  TRIM_X_NOTCH_LOW,
    input  wire logic [7:0]  TRIM_Y_NOTCH_LOW,
    input  wire logic [7:0]  TRIM_Z_NOTCH_LOW,
    input  wire logic [7:0]  TRIM_NOTCH_HIGH_SELECT,
    output logic      [2:0]  BANK_CHOICE,
    output logic             ACCEL_SELFTEST_SUPPLY,
    output logic      [5:0]  SELFTEST_ON,
    output logic      [5:0]  AXIS_OFF,
    output logic             GYRO_ANTIALIAS_BYPASS,
    output logic             GYRO_NOTCH_BYPASS,
    output logic      [5:0]  GYRO_ANTIALIAS_DELTA,
    output logic      [11:0] GYRO_ANTIALIAS_DELTA_SQUARED,
    output logic      [3:0]  GYRO_ANTIALIAS_SHIFT,
    output logic      [8:0]  GYRO_X_NOTCH_COEF,
    output logic      [8:0]  GYRO_Y_NOTCH_COEF,
    output logic      [8:0]  GYRO_Z_NOTCH_COEF,
    output logic             GYRO_X_NOTCH_SELECT,
    output logic             GYRO_Y_NOTCH_SELECT,
    output logic             GYRO_Z_NOTCH_SELECT
);
    typedef struct packed {
        logic [2:0] bank;
        logic [7:0] rd_data;
    } msc_state_t;

    msc_state_t st_q;
    msc_state_t st_d;

    logic       in_bank0;
    logic       in_bank1;
    logic [7:0] selftest_v;
    logic [7:0] axis_off_v;
    logic [7:0] bypass_v;
    logic [7:0] delta_v;
    logic [7:0] dsq_low_v;
    logic [7:0] shift_dsq_v;
    logic [7:0] notch_x_v;
    logic [7:0] notch_y_v;
    logic [7:0] notch_z_v;
    logic [7:0] notch_hi_v;

    // bank qualification for everything but the bank selector
    assign in_bank0 = (st_q.bank == BANK_0);
    assign in_bank1 = (st_q.bank == BANK_1);

    // bank 0 self-test control, supply bit kept by the host
    msc_cfg_byte #(.RESET_VAL(RST_ZERO), .WR_MASK(MASK_SELFTEST), .USE_TRIM(1'b0)) u_selftest (
        .clk      (CLK),
        .rst_b    (RST_B),
        .wr_en    (REG_WR_EN && in_bank0 && REG_ADDR == OFS_SELFTEST_CTRL),
        .wr_data  (REG_WR_DATA),
        .trim_val (RST_ZERO),
        .value    (selftest_v)
    );

    // bank 1 axis power-off, all axes on after reset
    msc_cfg_byte #(.RESET_VAL(RST_ZERO), .WR_MASK(MASK_AXIS_OFF), .USE_TRIM(1'b0)) u_axis_off (
        .clk      (CLK),
        .rst_b    (RST_B),
        .wr_en    (REG_WR_EN && in_bank1 && REG_ADDR == OFS_AXIS_POWER_OFF),
        .wr_data  (REG_WR_DATA),
        .trim_val (RST_ZERO),
        .value    (axis_off_v)
    );

    // bank 1 filter bypass bits
    msc_cfg_byte #(.RESET_VAL(RST_GYRO_BYPASS), .WR_MASK(MASK_BYPASS), .USE_TRIM(1'b0)) u_bypass (
        .clk      (CLK),
        .rst_b    (RST_B),
        .wr_en    (REG_WR_EN && in_bank1 && REG_ADDR == OFS_GYRO_BYPASS),
        .wr_data  (REG_WR_DATA),
        .trim_val (RST_ZERO),
        .value    (bypass_v)
    );

    // anti-alias bandwidth parameters
    msc_cfg_byte #(.RESET_VAL(RST_AAF_DELTA), .WR_MASK(MASK_AAF_DELTA), .USE_TRIM(1'b0)) u_delta (
        .clk      (CLK),
        .rst_b    (RST_B),
        .wr_en    (REG_WR_EN && in_bank1 && REG_ADDR == OFS_AAF_DELTA),
        .wr_data  (REG_WR_DATA),
        .trim_val (RST_ZERO),
        .value    (delta_v)
    );

    msc_cfg_byte #(.RESET_VAL(RST_AAF_DSQ_LOW), .WR_MASK(MASK_FULL), .USE_TRIM(1'b0)) u_dsq_low (
        .clk      (CLK),
        .rst_b    (RST_B),
        .wr_en    (REG_WR_EN && in_bank1 && REG_ADDR == OFS_AAF_DSQ_LOW),
        .wr_data  (REG_WR_DATA),
        .trim_val (RST_ZERO),
        .value    (dsq_low_v)
    );

    msc_cfg_byte #(.RESET_VAL(RST_AAF_SHIFT_DSQ_H), .WR_MASK(MASK_FULL), .USE_TRIM(1'b0)) u_shift_dsq (
        .clk      (CLK),
        .rst_b    (RST_B),
        .wr_en    (REG_WR_EN && in_bank1 && REG_ADDR == OFS_AAF_SHIFT_DSQ_H),
        .wr_data  (REG_WR_DATA),
        .trim_val (RST_ZERO),
        .value    (shift_dsq_v)
    );

    // notch coefficients come out of reset with factory trim
    msc_cfg_byte #(.RESET_VAL(RST_ZERO), .WR_MASK(MASK_FULL), .USE_TRIM(1'b1)) u_notch_x (
        .clk      (CLK),
        .rst_b    (RST_B),
        .wr_en    (REG_WR_EN && in_bank1 && REG_ADDR == OFS_NOTCH_X_LOW),
        .wr_data  (REG_WR_DATA),
        .trim_val (TRIM_X_NOTCH_LOW),
        .value    (notch_x_v)
    );

    msc_cfg_byte #(.RESET_VAL(RST_ZERO), .WR_MASK(MASK_FULL), .USE_TRIM(1'b1)) u_notch_y (
        .clk      (CLK),
        .rst_b    (RST_B),
        .wr_en    (REG_WR_EN && in_bank1 && REG_ADDR == OFS_NOTCH_Y_LOW),
        .wr_data  (REG_WR_DATA),
        .trim_val (TRIM_Y_NOTCH_LOW),
        .value    (notch_y_v)
    );

    msc_cfg_byte #(.RESET_VAL(RST_ZERO), .WR_MASK(MASK_FULL), .USE_TRIM(1'b1)) u_notch_z (
        .clk      (CLK),
        .rst_b    (RST_B),
        .wr_en    (REG_WR_EN && in_bank1 && REG_ADDR == OFS_NOTCH_Z_LOW),
        .wr_data  (REG_WR_DATA),
        .trim_val (TRIM_Z_NOTCH_LOW),
        .value    (notch_z_v)
    );

    msc_cfg_byte #(.RESET_VAL(RST_ZERO), .WR_MASK(MASK_NOTCH_HIGH), .USE_TRIM(1'b1)) u_notch_hi (
        .clk      (CLK),
        .rst_b    (RST_B),
        .wr_en    (REG_WR_EN && in_bank1 && REG_ADDR == OFS_NOTCH_HIGH_SEL),
        .wr_data  (REG_WR_DATA),
        .trim_val (TRIM_NOTCH_HIGH_SELECT),
        .value    (notch_hi_v)
    );

    // bank selector update and registered read path
    always_comb begin
        st_d = st_q;
        // selector decodes whatever bank is active; reserved codes are dropped
        if (REG_WR_EN && REG_ADDR == OFS_BANK_CHOICE) begin
            if ((REG_WR_DATA & MASK_BANK_CHOICE) <= {5'h00, BANK_MAX}) begin
                st_d.bank = REG_WR_DATA[BANK_MSB:0];
            end
        end
        if (REG_RD_EN) begin
            st_d.rd_data = 8'h00;  // unmapped and reserved read zero
            if (REG_ADDR == OFS_BANK_CHOICE) begin
                st_d.rd_data = {5'h00, st_q.bank};
            end else if (in_bank0) begin
                case (REG_ADDR)
                    OFS_DROPPED_LOW:   st_d.rd_data = DROPPED_PACKET_COUNT[COUNT_LOW_MSB:0];
                    OFS_DROPPED_HIGH:  st_d.rd_data = DROPPED_PACKET_COUNT[COUNT_HIGH_MSB:COUNT_HIGH_LSB];
                    OFS_SELFTEST_CTRL: st_d.rd_data = selftest_v;
                    OFS_PART_IDENTITY: st_d.rd_data = IDENTITY_VALUE;
                    default:           st_d.rd_data = 8'h00;
                endcase
            end else if (in_bank1) begin
                case (REG_ADDR)
                    OFS_AXIS_POWER_OFF:  st_d.rd_data = axis_off_v;
                    OFS_GYRO_BYPASS:     st_d.rd_data = bypass_v;
                    OFS_AAF_DELTA:       st_d.rd_data = delta_v;
                    OFS_AAF_DSQ_LOW:     st_d.rd_data = dsq_low_v;
                    OFS_AAF_SHIFT_DSQ_H: st_d.rd_data = shift_dsq_v;
                    OFS_NOTCH_X_LOW:     st_d.rd_data = notch_x_v;
                    OFS_NOTCH_Y_LOW:     st_d.rd_data = notch_y_v;
                    OFS_NOTCH_Z_LOW:     st_d.rd_data = notch_z_v;
                    OFS_NOTCH_HIGH_SEL:  st_d.rd_data = notch_hi_v;
                    default:             st_d.rd_data = 8'h00;
                endcase
            end
        end
    end

    // bank 0 after reset, read data cleared
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            st_q.bank    <= BANK_0;
            st_q.rd_data <= RST_ZERO;
        end else begin
            st_q <= st_d;
        end
    end

    // field outputs straight from the register flops
    assign REG_RD_DATA                  = st_q.rd_data;
    assign BANK_CHOICE                  = st_q.bank;
    assign ACCEL_SELFTEST_SUPPLY        = selftest_v[SELFTEST_SUPPLY_BIT];
    assign SELFTEST_ON                  = selftest_v[SELFTEST_EN_MSB:0];
    assign AXIS_OFF                     = axis_off_v[AXIS_OFF_MSB:0];
    assign GYRO_ANTIALIAS_BYPASS        = bypass_v[AAF_BYPASS_BIT];
    assign GYRO_NOTCH_BYPASS            = bypass_v[NOTCH_BYPASS_BIT];
    assign GYRO_ANTIALIAS_DELTA         = delta_v[AAF_DELTA_MSB:0];
    assign GYRO_ANTIALIAS_DELTA_SQUARED = {shift_dsq_v[DSQ_HIGH_MSB:0], dsq_low_v};
    assign GYRO_ANTIALIAS_SHIFT         = shift_dsq_v[AAF_SHIFT_MSB:AAF_SHIFT_LSB];
    assign GYRO_X_NOTCH_COEF            = {notch_hi_v[NOTCH_X_BIT8], notch_x_v};
    assign GYRO_Y_NOTCH_COEF            = {notch_hi_v[NOTCH_Y_BIT8], notch_y_v};
    assign GYRO_Z_NOTCH_COEF            = {notch_hi_v[NOTCH_Z_BIT8], notch_z_v};
    assign GYRO_X_NOTCH_SELECT          = notch_hi_v[NOTCH_X_SEL];
    assign GYRO_Y_NOTCH_SELECT          = notch_hi_v[NOTCH_Y_SEL];
    assign GYRO_Z_NOTCH_SELECT          = notch_hi_v[NOTCH_Z_SEL];
endmodule

// [tb/msc_host.sv]
// host model that drives the register port
`timescale 1ns/100ps
module msc_host (
    input  wire logic       clk,
    output logic      [6:0] reg_addr,
    output logic            reg_wr_en,
    output logic      [7:0] reg_wr_data,
    output logic            reg_rd_en,
    input  wire logic [7:0] reg_rd_data
);
    // port idle at time zero
    initial begin
        reg_addr = 7'h00;
        reg_wr_en = 1'b0;
        reg_wr_data = 8'h00;
        reg_rd_en = 1'b0;
    end
    // one-cycle write; bank codes come from the caller
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wr_data = d;
        reg_wr_en = 1'b1;
        @(negedge clk);
        reg_wr_en = 1'b0;
        reg_addr = ~a;  // released lines do not keep the old value
        reg_wr_data = ~d;
    endtask
    // one-cycle read; data is taken one cycle later
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge clk);
        d = reg_rd_data;
        reg_rd_en = 1'b0;
        reg_addr = ~a;
    endtask
endmodule

// [tb/msc_regs_asserts.sv]
// timing checks on the register port of the slice
`timescale 1ns/100ps
module msc_regs_asserts
    import msc_pkg::*;
#(
    parameter logic [7:0] IDENTITY_VALUE = 8'h5a
) (
    input wire logic        CLK,
    input wire logic        RST_B,
    input wire logic [6:0]  REG_ADDR,
    input wire logic        REG_WR_EN,
    input wire logic [7:0]  REG_WR_DATA,
    input wire logic        REG_RD_EN,
    input wire logic [7:0]  REG_RD_DATA,
    input wire logic [15:0] DROPPED_PACKET_COUNT,
    input wire logic [2:0]  BANK_CHOICE,
    input wire logic        ACCEL_SELFTEST_SUPPLY,
    input wire logic [5:0]  SELFTEST_ON,
    input wire logic [5:0]  AXIS_OFF
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RST_B);
    // read access qualifier for bank 0
    sequence rd0(a);
        REG_RD_EN && BANK_CHOICE == BANK_0 && REG_ADDR == a;
    endsequence
    a_bank_write: assert property (REG_WR_EN && REG_ADDR == OFS_BANK_CHOICE && REG_WR_DATA[2:0] <= BANK_MAX
        |=> BANK_CHOICE == $past(REG_WR_DATA[2:0])) else $error("bank write lost");
    a_bank_reserved: assert property (REG_WR_EN && REG_ADDR == OFS_BANK_CHOICE && REG_WR_DATA[2:0] > BANK_MAX
        |=> $stable(BANK_CHOICE)) else $error("reserved bank taken");
    a_bank_read: assert property (REG_RD_EN && REG_ADDR == OFS_BANK_CHOICE
        |=> REG_RD_DATA == {5'h00, $past(BANK_CHOICE)}) else $error("bank read wrong");
    a_id_read: assert property (rd0(OFS_PART_IDENTITY) |=> REG_RD_DATA == IDENTITY_VALUE)
        else $error("identity wrong");
    a_count_low: assert property (rd0(OFS_DROPPED_LOW) |=> REG_RD_DATA == $past(DROPPED_PACKET_COUNT[7:0]))
        else $error("count low wrong");
    a_count_high: assert property (rd0(OFS_DROPPED_HIGH) |=> REG_RD_DATA == $past(DROPPED_PACKET_COUNT[15:8]))
        else $error("count high wrong");
    a_selftest_write: assert property (REG_WR_EN && BANK_CHOICE == BANK_0 && REG_ADDR == OFS_SELFTEST_CTRL
        |=> {ACCEL_SELFTEST_SUPPLY, SELFTEST_ON} == $past(REG_WR_DATA[6:0])) else $error("selftest lost");
    a_axis_write: assert property (REG_WR_EN && BANK_CHOICE == BANK_1 && REG_ADDR == OFS_AXIS_POWER_OFF
        |=> AXIS_OFF == $past(REG_WR_DATA[5:0])) else $error("axis write lost");
    a_axis_isolate: assert property (REG_WR_EN && BANK_CHOICE != BANK_1 |=> $stable(AXIS_OFF))
        else $error("axis changed from other bank");
    // main scenarios reached
    c_bank_reserved: cover property (REG_WR_EN && REG_ADDR == OFS_BANK_CHOICE && REG_WR_DATA[2:0] == 3'h7);
    c_axis_write: cover property (REG_WR_EN && BANK_CHOICE == BANK_1 && REG_ADDR == OFS_AXIS_POWER_OFF);
    c_id_read: cover property (rd0(OFS_PART_IDENTITY));
endmodule

bind msc_regs msc_regs_asserts #(.IDENTITY_VALUE(IDENTITY_VALUE)) msc_regs_asserts_i (
    .CLK(CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR), .REG_WR_EN(REG_WR_EN), .REG_WR_DATA(REG_WR_DATA),
    .REG_RD_EN(REG_RD_EN), .REG_RD_DATA(REG_RD_DATA), .DROPPED_PACKET_COUNT(DROPPED_PACKET_COUNT),
    .BANK_CHOICE(BANK_CHOICE), .ACCEL_SELFTEST_SUPPLY(ACCEL_SELFTEST_SUPPLY), .SELFTEST_ON(SELFTEST_ON),
    .AXIS_OFF(AXIS_OFF));

// [tb/msc_regs_tb.sv]
// self-checking testbench for the register slice
`timescale 1ns/100ps
module msc_regs_tb
    import msc_pkg::*;
;
    localparam logic [7:0] ID = 8'h3c;  // arbitrary value
    logic CLK, RST_B;
    logic [15:0] cnt;
    logic [7:0]  tx, th;
    wire logic [6:0] addr;
    wire logic wr, rd, sup, aab, nb, sx, sy, sz;
    wire logic [7:0] wd, rdata;
    wire logic [2:0] bank;
    wire logic [5:0] st, axoff, dl;
    wire logic [11:0] dsq;
    wire logic [3:0] sh;
    wire logic [8:0] cx, cy, cz;
    int err_count, n_checks;
    msc_regs #(.IDENTITY_VALUE(ID)) msc_regs_i (.CLK(CLK), .RST_B(RST_B), .REG_ADDR(addr), .REG_WR_EN(wr),
        .REG_WR_DATA(wd), .REG_RD_EN(rd), .REG_RD_DATA(rdata), .DROPPED_PACKET_COUNT(cnt),
        .TRIM_X_NOTCH_LOW(tx), .TRIM_Y_NOTCH_LOW(~tx), .TRIM_Z_NOTCH_LOW(tx ^ 8'h0f),
        .TRIM_NOTCH_HIGH_SELECT(th), .BANK_CHOICE(bank), .ACCEL_SELFTEST_SUPPLY(sup), .SELFTEST_ON(st),
        .AXIS_OFF(axoff), .GYRO_ANTIALIAS_BYPASS(aab), .GYRO_NOTCH_BYPASS(nb), .GYRO_ANTIALIAS_DELTA(dl),
        .GYRO_ANTIALIAS_DELTA_SQUARED(dsq), .GYRO_ANTIALIAS_SHIFT(sh), .GYRO_X_NOTCH_COEF(cx),
        .GYRO_Y_NOTCH_COEF(cy), .GYRO_Z_NOTCH_COEF(cz), .GYRO_X_NOTCH_SELECT(sx),
        .GYRO_Y_NOTCH_SELECT(sy), .GYRO_Z_NOTCH_SELECT(sz));
    msc_host msc_host_i (.clk(CLK), .reg_addr(addr), .reg_wr_en(wr), .reg_wr_data(wd), .reg_rd_en(rd),
        .reg_rd_data(rdata));
    // 100 ns clock
    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] d;
        msc_host_i.rd(a, d);
        chk({8'h00, d}, {8'h00, exp});
    endtask
    task automatic wrap_up;
        $display("mismatches %0d comparisons %0d", err_count, n_checks);
        if (err_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // reset for two cycles with given trim, then check every reset value
    task automatic t_reset(input logic [7:0] x, input logic [7:0] h);
        @(negedge CLK);
        RST_B = 1'b0;
        tx = x;
        th = h;
        repeat (2) @(negedge CLK);
        RST_B = 1'b1;
        chk(16'(axoff), 16'h0000);
        chk(16'({aab, nb}), 16'h0000);
        chk(16'(dl), 16'h003f);
        chk(16'(dsq), 16'h0f80);
        chk(16'(sh), 16'h0003);
        chk(16'(cx), 16'({h[0], x}));
        chk(16'(cy), 16'({h[1], ~x}));
        chk(16'(cz), 16'({h[2], x ^ 8'h0f}));
        chk(16'({sz, sy, sx}), 16'(h[5:3]));
        chk(16'({bank, sup, st}), 16'h0000);
        rdc(OFS_PART_IDENTITY, ID);
    endtask
    // live count bytes, read-only
    task automatic t_count;
        cnt = 16'hbeef;
        rdc(OFS_DROPPED_LOW, 8'hef);
        rdc(OFS_DROPPED_HIGH, 8'hbe);
        msc_host_i.wr(OFS_DROPPED_LOW, 8'h00);
        rdc(OFS_DROPPED_LOW, 8'hef);
        msc_host_i.wr(OFS_PART_IDENTITY, 8'h00);
        rdc(OFS_PART_IDENTITY, ID);
    endtask
    // self-test enables, supply bit set then cleared
    task automatic t_selftest;
        msc_host_i.wr(OFS_SELFTEST_CTRL, 8'hff);
        chk(16'({sup, st}), 16'h007f);
        rdc(OFS_SELFTEST_CTRL, 8'h7f);
        msc_host_i.wr(OFS_SELFTEST_CTRL, 8'h00);
        chk(16'({sup, st}), 16'h0000);
    endtask
    // every bank code, reserved codes refused
    task automatic t_banks;
        logic [2:0] e;
        e = 3'h0;
        for (int b = 0; b < 8; b++) begin
            msc_host_i.wr(OFS_BANK_CHOICE, {5'h1f, 3'(b)});
            if (b <= 4) e = 3'(b);
            chk(16'(bank), 16'(e));
            rdc(OFS_BANK_CHOICE, {5'h00, e});
            rdc(OFS_PART_IDENTITY, (e == 3'h0) ? ID : 8'h00);
        end
        msc_host_i.wr(OFS_BANK_CHOICE, 8'h00);
    endtask
    // bank 1 filter and axis fields, then a bank 0 write to the same offset
    task automatic t_bank1;
        msc_host_i.wr(OFS_BANK_CHOICE, 8'h01);
        msc_host_i.wr(OFS_AXIS_POWER_OFF, 8'hff);
        chk(16'(axoff), 16'h003f);
        rdc(OFS_AXIS_POWER_OFF, 8'h3f);
        msc_host_i.wr(OFS_GYRO_BYPASS, 8'hfe);
        chk(16'({aab, nb}), 16'h0002);
        rdc(OFS_GYRO_BYPASS, 8'h02);
        msc_host_i.wr(OFS_AAF_DELTA, 8'hea);
        msc_host_i.wr(OFS_AAF_DSQ_LOW, 8'h5c);
        msc_host_i.wr(OFS_AAF_SHIFT_DSQ_H, 8'h9b);
        chk(16'(dl), 16'h002a);
        chk(16'(dsq), 16'h0b5c);
        chk(16'(sh), 16'h0009);
        msc_host_i.wr(OFS_NOTCH_X_LOW, 8'h11);
        msc_host_i.wr(OFS_NOTCH_Y_LOW, 8'h22);
        msc_host_i.wr(OFS_NOTCH_Z_LOW, 8'h33);
        msc_host_i.wr(OFS_NOTCH_HIGH_SEL, 8'hed);
        chk(16'(cx), 16'h0111);
        chk(16'(cy), 16'h0022);
        chk(16'(cz), 16'h0133);
        chk(16'({sz, sy, sx}), 16'h0005);
        rdc(OFS_NOTCH_HIGH_SEL, 8'h2d);
        msc_host_i.wr(OFS_BANK_CHOICE, 8'h00);
        msc_host_i.wr(OFS_AXIS_POWER_OFF, 8'h00);
        chk(16'(axoff), 16'h003f);
        rdc(OFS_AXIS_POWER_OFF, 8'h00);
    endtask
    // main sequence, with a second reset after configuring
    initial begin
        RST_B = 1'b0;
        cnt = 16'h0000;
        tx = 8'h00;
        th = 8'h00;
        err_count = 0;
        n_checks = 0;
        t_reset(8'h5e, 8'h3f);
        t_count();
        t_selftest();
        t_banks();
        t_bank1();
        t_reset(8'ha1, 8'h12);
        wrap_up();
    end
    // cut a hang short after 500 cycles
    initial begin
        #50000;
        err_count++;
        wrap_up();
    end
endmodule
